// *** dv/lsu_checker.sv ***
// port assertions for the byte order unit
// bound onto lsu_byte_order_unit at the foot
`timescale 1ns/1ps
`default_nettype none
module lsu_checker (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire logic req_ready_out,
	input wire logic [2:0] req_page_attr_in,
	input wire logic mem_ack_in,
	input wire logic mem_req_out,
	input wire logic [63:0] mem_addr_out,
	input wire lsu_pkg::acc_type_t mem_acc_type_out,
	input wire logic mem_cache_lookup_out,
	input wire logic align_err_out
);
	import lsu_pkg::*;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	AST_NO_XFER: assert property (align_err_out |-> !mem_req_out) else $error("request on align error");
	AST_UNC_NOCACHE: assert property (mem_req_out && mem_acc_type_out != ACC_CACHED |-> !mem_cache_lookup_out)
		else $error("cache touched");
	AST_CACHED: assert property (mem_req_out && mem_acc_type_out == ACC_CACHED |-> mem_cache_lookup_out)
		else $error("cached without lookup");
	AST_LANE_ADDR: assert property (mem_req_out |-> mem_addr_out[2:0] == 3'h0) else $error("addr low bits");
	AST_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
		else $error("request dropped");
	AST_ONE_REQ: assert property (mem_ack_in && mem_req_out |=> !mem_req_out) else $error("merged");
	AST_TAKEN: assert property (req_valid_in && req_ready_out |=> mem_req_out ^ align_err_out)
		else $error("no answer");
	AST_ATTR: assert property (req_valid_in && req_ready_out && req_page_attr_in == ATTR_UNCACHED
		|=> align_err_out || mem_acc_type_out == ACC_UNCACHED) else $error("wrong type");
	C_ERR: cover property (align_err_out);
	C_CACHED: cover property (mem_req_out && mem_cache_lookup_out);
	C_ACK: cover property (mem_req_out && mem_ack_in);
endmodule // lsu_checker
bind lsu_byte_order_unit lsu_checker i_chk (.clk_sys_in, .rst_n_in, .req_valid_in, .req_ready_out,
	.req_page_attr_in, .mem_ack_in, .mem_req_out, .mem_addr_out, .mem_acc_type_out, .mem_cache_lookup_out,
	.align_err_out);
`default_nettype wire

// *** dv/lsu_mem_model.sv ***
// memory partner: acks each request, holds one 64-bit word
// assumes the request stays stable until acked
`timescale 1ns/1ps
`default_nettype none
module lsu_mem_model (
	input wire logic clk_sys_in,
	input wire logic slow_in,
	input wire logic mem_req_out,
	input wire logic mem_we_out,
	input wire logic [7:0] mem_byte_en_out,
	input wire logic [63:0] mem_wdata_out,
	output logic mem_ack_in,
	output logic [63:0] mem_rdata_in
);
	logic [63:0] word = 64'h0;
	int n = 0;
	initial mem_ack_in = 1'b0;
	initial mem_rdata_in = 64'h0;
	always @(posedge clk_sys_in) begin
		#1;
		// idle data toggles so stale lanes never look valid
		mem_rdata_in = ~mem_rdata_in;
		if (mem_ack_in) begin
			mem_ack_in = 1'b0;
			n = 0;
		end else if (mem_req_out) begin
			n++;
			if (n > (slow_in ? 4 : 1)) begin
				mem_ack_in = 1'b1;
				mem_rdata_in = word;
				for (int k = 0; k < 8; k++)
					if (mem_we_out && mem_byte_en_out[k]) word[8*k+:8] = mem_wdata_out[8*k+:8];
			end
		end
	end
endmodule // lsu_mem_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the byte order unit
// memory side is lsu_mem_model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lsu_pkg::*;
	logic clk_sys_in = 0, rst_n_in = 0, big_endian_in = 0, req_valid_in = 0, req_store_in = 0, slow = 0;
	lsu_op_t req_op_in = OP_BYTE;
	logic [63:0] req_vaddr_in = 0, req_paddr_in = 0, req_wdata_in = 64'h1122334455667788, mem_rdata_in;
	logic [2:0] req_page_attr_in = 0;
	logic mem_ack_in, req_ready_out, mem_req_out, mem_we_out, mem_cache_lookup_out, ld_valid_out, align_err_out;
	logic [63:0] mem_addr_out, mem_wdata_out, ld_data_out, r_wd, r_ad, r_ld;
	logic [7:0] mem_byte_en_out, ld_byte_en_out, r_be;
	acc_type_t mem_acc_type_out, r_ty;
	logic r_err, r_lk, r_we;
	int n_fail = 0, checks_done = 0;
	lsu_byte_order_unit i_dut (.clk_sys_in, .rst_n_in, .big_endian_in, .req_valid_in, .req_store_in, .req_op_in,
		.req_vaddr_in, .req_paddr_in, .req_page_attr_in, .req_wdata_in, .mem_ack_in, .mem_rdata_in, .req_ready_out,
		.mem_req_out, .mem_we_out, .mem_addr_out, .mem_byte_en_out, .mem_wdata_out, .mem_acc_type_out,
		.mem_cache_lookup_out, .ld_valid_out, .ld_data_out, .ld_byte_en_out, .align_err_out);
	lsu_mem_model i_mem (.clk_sys_in, .slow_in(slow), .mem_req_out, .mem_we_out, .mem_byte_en_out, .mem_wdata_out,
		.mem_ack_in, .mem_rdata_in);
	initial forever #25 clk_sys_in = ~clk_sys_in;
	task print_verdict;
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [63:0] lanes(input logic [7:0] b);
		for (int k = 0; k < 8; k++) lanes[8*k+:8] = {8{b[k]}};
	endfunction
	// one access, entered just after an edge while ready is up
	task automatic acc(input logic st, input lsu_op_t op, input logic [63:0] va, input logic [2:0] at);
		int i;
		req_store_in = st;
		req_op_in = op;
		req_vaddr_in = va;
		req_paddr_in = va ^ 64'hF005;
		req_page_attr_in = at;
		req_valid_in = 1'b1;
		@(posedge clk_sys_in);
		#1;
		req_valid_in = 1'b0;
		r_err = align_err_out;
		r_be = mem_byte_en_out;
		r_wd = mem_wdata_out;
		r_ty = mem_acc_type_out;
		r_lk = mem_cache_lookup_out;
		r_ad = mem_addr_out;
		r_we = mem_we_out;
		for (i = 0; i < 20 && !req_ready_out; i++) begin
			@(posedge clk_sys_in);
			#1;
		end
		if (i == 20) begin
			n_fail++;
			print_verdict;
		end
		chk(ld_valid_out, !st && !r_err);
		r_ld = ld_data_out;
		// idle edge so valid never falls and rises in one time step
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic t_store(input logic be, input lsu_op_t op, input logic [2:0] a, input logic [7:0] eb, int sh);
		big_endian_in = be;
		acc(1'b1, op, {61'h0, a}, 3'h0);
		chk(r_be, eb);
		chk(r_wd & lanes(eb), (req_wdata_in << sh) & lanes(eb));
		chk(r_we, 1'b1);
	endtask
	// left and right parts: lanes run from the address to the container end (BE left, LE right) or from the container start to the address
	task t_part;
		t_store(1'b1, OP_WORD_LEFT, 3'h3, 8'h10, 32);
		t_store(1'b0, OP_WORD_RIGHT, 3'h1, 8'h0E, 8);
		t_store(1'b0, OP_DWORD_LEFT, 3'h5, 8'h3F, 0);
		t_store(1'b1, OP_DWORD_RIGHT, 3'h2, 8'hE0, 40);
	endtask
	task t_load;
		big_endian_in = 1'b0;
		acc(1'b1, OP_DWORD, 64'h0, 3'h0);
		acc(1'b0, OP_WORD, 64'h4, 3'h0);
		chk(r_ld[31:0], 64'h11223344);
		chk(ld_byte_en_out, 8'hF0);
		chk(r_we, 1'b0);
		big_endian_in = 1'b1;
		acc(1'b0, OP_WORD, 64'h4, 3'h0);
		chk(r_ld[31:0], 64'h55667788);
		chk(ld_byte_en_out, 8'h0F);
		acc(1'b0, OP_HALF, 64'h0, 3'h0);
		chk(r_ld[15:0], 64'h1122);
		chk(ld_byte_en_out, 8'hC0);
	endtask
	task t_align;
		lsu_op_t ops [6] = '{OP_HALF, OP_WORD, OP_DWORD, OP_BYTE, OP_WORD_LEFT, OP_VEC128};
		for (int k = 0; k < 6; k++) begin
			acc(1'b0, ops[k], 64'h3 - (k == 1), 3'h0);
			chk(r_err, k < 3);
		end
	endtask
	task t_attr;
		logic [2:0] at [3] = '{3'h2, 3'h7, 3'h0};
		slow = 1'b1;
		for (int k = 0; k < 3; k++) begin
			acc(1'b1, OP_WORD, 64'h12C, at[k]);
			chk(r_ty, k == 0 ? ACC_UNCACHED : k == 1 ? ACC_UNCACHED_ACCEL : ACC_CACHED);
			chk(r_lk, k == 2);
			chk(r_ad, 64'hF128);
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b1;
		repeat (2) @(posedge clk_sys_in);
		#1;
		t_store(1'b0, OP_HALF, 3'h2, 8'h0C, 16);
		t_store(1'b0, OP_WORD, 3'h4, 8'hF0, 32);
		t_store(1'b1, OP_WORD, 3'h4, 8'h0F, 0);
		t_store(1'b1, OP_HALF, 3'h2, 8'h30, 32);
		t_store(1'b1, OP_BYTE, 3'h1, 8'h40, 48);
		t_part;
		t_load;
		t_align;
		t_attr;
		print_verdict;
	end
endmodule // testbench
`default_nettype wire

// *** hdl/lsu_byte_order_unit.sv ***
// load/store byte order unit: lane steering, alignment check, access type
// pipeline gives one request at a time and holds it until accepted
// memory side answers with mem_ack_in, load data in lanes
`timescale 1ns/1ps
`default_nettype none
module lsu_byte_order_unit #(
	parameter bit HAS_UNCACHED_ACCEL = 1'b1
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic big_endian_in,
	input wire logic req_valid_in,
	input wire logic req_store_in,
	input wire lsu_pkg::lsu_op_t req_op_in,
	input wire logic [63:0] req_vaddr_in,
	input wire logic [63:0] req_paddr_in,
	input wire logic [2:0] req_page_attr_in,
	input wire logic [63:0] req_wdata_in,
	input wire logic mem_ack_in,
	input wire logic [63:0] mem_rdata_in,
	output logic req_ready_out,
	output logic mem_req_out,
	output logic mem_we_out,
	output logic [63:0] mem_addr_out,
	output logic [7:0] mem_byte_en_out,
	output logic [63:0] mem_wdata_out,
	output var lsu_pkg::acc_type_t mem_acc_type_out,
	output logic mem_cache_lookup_out,
	output logic ld_valid_out,
	output logic [63:0] ld_data_out,
	output logic [7:0] ld_byte_en_out,
	output logic align_err_out
);
	import lsu_pkg::*;
	logic [7:0] be;
	logic [2:0] sh;
	logic mis;
	lsu_state_t state_q, state_d;
	logic ready_q, ready_d;
	logic req_q, req_d;
	logic we_q, we_d;
	logic [63:0] addr_q, addr_d;
	logic [7:0] be_q, be_d;
	logic [63:0] wd_q, wd_d;
	acc_type_t acc_q, acc_d;
	logic look_q, look_d;
	logic [2:0] sh_q, sh_d;
	logic ldv_q, ldv_d;
	logic [63:0] ld_q, ld_d;
	logic [7:0] ldbe_q, ldbe_d;
	logic err_q, err_d;
	acc_type_t acc_sel;
	logic accept;
	logic take;
	logic done;
	logic [63:0] wd_lanes;
	logic [63:0] ld_lanes;

	lsu_lane_steer u_steer (
		.op_in(req_op_in),
		.addr_lo_in(req_vaddr_in[2:0]),
		.big_endian_in(big_endian_in),
		.byte_en_out(be),
		.shift_out(sh),
		.misalign_out(mis)
	);

	// type from the page attribute only; paddr and opcode play no part
	always_comb begin
		if (req_page_attr_in == ATTR_UNCACHED) begin
			acc_sel = ACC_UNCACHED;
		end else if (HAS_UNCACHED_ACCEL && req_page_attr_in == ATTR_UNCACHED_ACCEL) begin
			acc_sel = ACC_UNCACHED_ACCEL;
		end else begin
			acc_sel = ACC_CACHED;
		end
	end

	// taken only from idle with ready up; a misaligned access only raises the flag
	assign accept = (state_q == ST_IDLE) && req_valid_in && ready_q;
	assign take = accept && !mis;
	assign done = (state_q == ST_WAIT) && mem_ack_in;

	// per lane: a store byte moves up by sh lanes, a load byte moves down by sh_q lanes
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [3:0] st_pos;
		logic [3:0] ld_pos;
		// bit 3 set: source lies outside the dword, lane reads zero
		assign st_pos = 4'(g) - {1'b0, sh};
		assign ld_pos = 4'(g) + {1'b0, sh_q};
		assign wd_lanes[8*g+:8] = st_pos[3] ? 8'h00 : req_wdata_in[8*st_pos[2:0]+:8];
		assign ld_lanes[8*g+:8] = ld_pos[3] ? 8'h00 : mem_rdata_in[8*ld_pos[2:0]+:8];
	end

	// control group: state, ready, request strobe, cache lookup
	always_comb begin
		state_d = state_q;
		ready_d = ready_q;
		req_d = req_q;
		look_d = look_q;
		case (state_q)
			ST_IDLE: begin
				ready_d = 1'b1;
				if (take) begin
					// one request per access; no store merging is done here
					state_d = ST_WAIT;
					ready_d = 1'b0;
					req_d = 1'b1;
					look_d = (acc_sel == ACC_CACHED);
				end
			end
			ST_WAIT: begin
				if (mem_ack_in) begin
					state_d = ST_IDLE;
					ready_d = 1'b1;
					req_d = 1'b0;
					look_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				ready_d = 1'b0;
				req_d = 1'b0;
				look_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
			ready_q <= 1'b0;
			req_q <= 1'b0;
			look_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ready_q <= ready_d;
			req_q <= req_d;
			look_q <= look_d;
		end
	end

	// request group: held unchanged while the memory request stands
	always_comb begin
		we_d = we_q;
		addr_d = addr_q;
		be_d = be_q;
		wd_d = wd_q;
		acc_d = acc_q;
		sh_d = sh_q;
		if (take) begin
			we_d = req_store_in;
			addr_d = {req_paddr_in[63:3], 3'h0};
			be_d = be;
			wd_d = wd_lanes;
			acc_d = acc_sel;
			sh_d = sh;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			we_q <= 1'b0;
			addr_q <= 64'h0;
			be_q <= 8'h00;
			wd_q <= 64'h0;
			acc_q <= ACC_UNCACHED;
			sh_q <= 3'h0;
		end else begin
			we_q <= we_d;
			addr_q <= addr_d;
			be_q <= be_d;
			wd_q <= wd_d;
			acc_q <= acc_d;
			sh_q <= sh_d;
		end
	end

	// load return group: right-justified, so bit 0 of the datum is bit 0 of the result
	always_comb begin
		ldv_d = 1'b0;
		ld_d = ld_q;
		ldbe_d = ldbe_q;
		if (done && !we_q) begin
			ldv_d = 1'b1;
			ld_d = ld_lanes;
			ldbe_d = be_q;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ldv_q <= 1'b0;
			ld_q <= 64'h0;
			ldbe_q <= 8'h00;
		end else begin
			ldv_q <= ldv_d;
			ld_q <= ld_d;
			ldbe_q <= ldbe_d;
		end
	end

	// error group: flag stands one cycle, ready stays up for the next access
	always_comb begin
		err_d = accept && mis;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_q <= 1'b0;
		end else begin
			err_q <= err_d;
		end
	end

	assign req_ready_out = ready_q;
	assign mem_req_out = req_q;
	assign mem_we_out = we_q;
	assign mem_addr_out = addr_q;
	assign mem_byte_en_out = be_q;
	assign mem_wdata_out = wd_q;
	assign mem_acc_type_out = acc_q;
	assign mem_cache_lookup_out = look_q;
	assign ld_valid_out = ldv_q;
	assign ld_data_out = ld_q;
	assign ld_byte_en_out = ldbe_q;
	assign align_err_out = err_q;
endmodule // lsu_byte_order_unit
`default_nettype wire

// *** hdl/lsu_lane_steer.sv ***
// lane steering: computes byte enables and lane shift for one access
// purely combinational; caller registers the results
`timescale 1ns/1ps
`default_nettype none
module lsu_lane_steer (
	input wire lsu_pkg::lsu_op_t op_in,
	input wire logic [2:0] addr_lo_in,
	input wire logic big_endian_in,
	output logic [7:0] byte_en_out,
	output logic [2:0] shift_out,
	output logic misalign_out
);
	import lsu_pkg::*;
	logic [3:0] size;
	logic [2:0] first;
	logic [3:0] span;
	always_comb begin
		size = 4'h1;
		span = 4'h1;
		misalign_out = 1'b0;
		// big endian lane of byte k in dword is 7-k; little endian k
		first = addr_lo_in;
		case (op_in)
			OP_BYTE: size = 4'h1;
			OP_HALF: begin
				size = 4'h2;
				misalign_out = |(addr_lo_in[1:0] & ALIGN_HALF_MASK);
			end
			OP_WORD: begin
				size = 4'h4;
				misalign_out = |(addr_lo_in & ALIGN_WORD_MASK);
			end
			OP_DWORD, OP_VEC128: begin
				size = 4'h8;
				misalign_out = (op_in == OP_DWORD) && |(addr_lo_in & ALIGN_DWORD_MASK);
			end
			// left part covers address to end of its word/dword container in big endian, container start to address in little endian
			OP_WORD_LEFT: size = big_endian_in ? 4'(4 - addr_lo_in[1:0]) : 4'(addr_lo_in[1:0] + 1);
			OP_WORD_RIGHT: size = big_endian_in ? 4'(addr_lo_in[1:0] + 1) : 4'(4 - addr_lo_in[1:0]);
			OP_DWORD_LEFT: size = big_endian_in ? 4'(8 - addr_lo_in) : 4'(addr_lo_in + 1);
			OP_DWORD_RIGHT: size = big_endian_in ? 4'(addr_lo_in + 1) : 4'(8 - addr_lo_in);
			default: size = 4'h1;
		endcase
		span = size;
		// lowest address byte covered by the access
		case (op_in)
			OP_HALF: first = {addr_lo_in[2:1], 1'b0};
			OP_WORD: first = {addr_lo_in[2], 2'h0};
			OP_DWORD, OP_VEC128: first = 3'h0;
			OP_WORD_LEFT: first = big_endian_in ? addr_lo_in : {addr_lo_in[2], 2'h0};
			OP_WORD_RIGHT: first = big_endian_in ? {addr_lo_in[2], 2'h0} : addr_lo_in;
			OP_DWORD_LEFT: first = big_endian_in ? addr_lo_in : 3'h0;
			OP_DWORD_RIGHT: first = big_endian_in ? 3'h0 : addr_lo_in;
			default: first = addr_lo_in;
		endcase
		byte_en_out = 8'h00;
		for (int k = 0; k < LANES; k++) begin
			if ((k >= int'(first)) && (k < int'(first) + int'(span))) begin
				byte_en_out[big_endian_in ? 7 - k : k] = 1'b1;
			end
		end
		// lane of the lowest-significance byte of the datum
		shift_out = big_endian_in ? 3'(~first - 3'(span - 4'h1)) : first;
		if (misalign_out) begin
			byte_en_out = 8'h00;
		end
	end
endmodule // lsu_lane_steer
`default_nettype wire

// *** hdl/lsu_pkg.sv ***
// constants for the load/store byte order unit
// assumes a 64-bit data path and one processor clock
package lsu_pkg;
	typedef enum logic [3:0] {
		OP_BYTE = 4'h0,
		OP_HALF = 4'h1,
		OP_WORD = 4'h2,
		OP_DWORD = 4'h3,
		OP_WORD_LEFT = 4'h4,
		OP_WORD_RIGHT = 4'h5,
		OP_DWORD_LEFT = 4'h6,
		OP_DWORD_RIGHT = 4'h7,
		OP_VEC128 = 4'h8
	} lsu_op_t;
	typedef enum logic [1:0] {
		ACC_UNCACHED = 2'h0,
		ACC_CACHED = 2'h1,
		ACC_UNCACHED_ACCEL = 2'h2
	} acc_type_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1
	} lsu_state_t;
	localparam int DATA_W = 64;
	localparam int ADDR_W = 64;
	localparam int LANES = 8;
	localparam int ATTR_W = 3;
	// attribute encodings; anything else counts as cached
	localparam logic [2:0] ATTR_UNCACHED = 3'h2;
	localparam logic [2:0] ATTR_UNCACHED_ACCEL = 3'h7;
	localparam logic [1:0] ALIGN_HALF_MASK = 2'h1;
	localparam logic [2:0] ALIGN_WORD_MASK = 3'h3;
	localparam logic [2:0] ALIGN_DWORD_MASK = 3'h7;
endpackage : lsu_pkg
